// File: irtxc_regs.svh
`ifndef IRTXC_REGS_SVH
`define IRTXC_REGS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define IRTXC_OFS_CTRL1   8'h00
`define IRTXC_OFS_CFG     8'h04
`define IRTXC_OFS_STATUS  8'h08
`define IRTXC_OFS_IRQ_STS 8'h0C
`define IRTXC_OFS_IRQ_MSK 8'h10

// ----------------------------------------
// Control register one fields
// ----------------------------------------
`define IRTXC_B_PULSE     3
`define IRTXC_B_FLUSH     4
`define IRTXC_B_BADCRC    5
`define IRTXC_B_CNTEN     6
`define IRTXC_B_MODEPROG  7
`define IRTXC_CTRL1_RST   8'h00

// ----------------------------------------
// Configuration fields
// ----------------------------------------
`define IRTXC_B_MODE_LO   0
`define IRTXC_B_SD_INV    2
`define IRTXC_CFG_RST     8'h00

// ----------------------------------------
// Interrupt event bits
// ----------------------------------------
`define IRTXC_EV_PULSE    0
`define IRTXC_EV_FLUSH    1
`define IRTXC_EV_ABORT    2
`define IRTXC_EV_MODEPROG 3
`define IRTXC_EV_W        4

// ----------------------------------------
// Timing
// ----------------------------------------
`define IRTXC_CLK_HZ      20000000
`define IRTXC_STEP_NS     300
`define IRTXC_PULSE_NS    2000
`define IRTXC_STEP_CYC    ((`IRTXC_STEP_NS * (`IRTXC_CLK_HZ / 1000000) + 999) / 1000)
`define IRTXC_PULSE_CYC   ((`IRTXC_PULSE_NS * (`IRTXC_CLK_HZ / 1000000) + 999) / 1000)
`define IRTXC_CNT_W       8

`endif

// File: irtxc_pkg.sv
package irtxc_pkg;

  typedef enum logic [1:0] {
    IRTXC_SIR  = 2'h0,
    IRTXC_XSIR = 2'h1,
    IRTXC_MIR  = 2'h2,
    IRTXC_FIR  = 2'h3
  } irtxc_mode_t;

  typedef enum logic [1:0] {
    IRTXC_MP_IDLE  = 2'h0,
    IRTXC_MP_STEP1 = 2'h1,
    IRTXC_MP_STEP2 = 2'h2
  } irtxc_mp_state_t;

  typedef enum logic [1:0] {
    IRTXC_PL_IDLE = 2'h0,
    IRTXC_PL_WAIT = 2'h1,
    IRTXC_PL_EMIT = 2'h2,
    IRTXC_PL_DONE = 2'h3
  } irtxc_pl_state_t;

endpackage

// File: irtxc_timer.sv
`timescale 1ns/1ps
`include "irtxc_regs.svh"

// ----------------------------------------
// Down-counting interval timer
// ----------------------------------------
module irtxc_timer (
  // Clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_n,
  // Control
  input  wire logic                    i_start,
  input  wire logic [`IRTXC_CNT_W-1:0] i_len,
  // Status
  output logic                         o_busy,
  output logic                         o_done
);

  logic [`IRTXC_CNT_W-1:0] cnt_r;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= 8'h00;
    end else if (i_start) begin
      cnt_r <= i_len - 8'h01;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_done <= 1'b0;
    end else begin
      o_done <= !i_start && (cnt_r == 8'h01);
    end
  end

  assign o_busy = (cnt_r != 8'h00);

endmodule

// File: irtxc_top.sv
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`include "irtxc_regs.svh"

// Function
// - Writing pulse request emits one roughly 2 us pulse on transmit pin.
// - Pulse follows first closing flag after request; bit clears after frame ends.
// - Pulse request works only in MIR and FIR; ignored in SIR modes.
// - Flush empties FIFO and holding registers; threshold and shift registers kept.
// - Flush bit returns to zero once the FIFO reports empty.
// - With abort bit, underrun truncates frame, adds inverted CRC and end flag.
// - Clearing abort bit disables it; works only in MIR and FIR.
// - Byte counter runs only while its enable bit is one.
// - Counter enable honoured in extended SIR, MIR, FIR; ignored in SIR.
// - FIR mode program: shutdown on, tx high; 300 ns shutdown off; 300 ns tx low.
// - Other modes: shutdown on, tx low; 300 ns shutdown off; tx low 300 ns.
// - Mode program bit clears itself when the pin sequence finishes.
// - Shutdown levels invert when shutdown pin is configured active low.
module irtxc_top (
  // Clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_ARST_N,
  // AXI4-Lite write address
  input  wire logic [7:0]  I_AWADDR,
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  // AXI4-Lite write data
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  // AXI4-Lite write response
  output logic [1:0]       O_BRESP,
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  // AXI4-Lite read address
  input  wire logic [7:0]  I_ARADDR,
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  // AXI4-Lite read data
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  // Framer side
  input  wire logic        I_CLOSING_FLAG,
  input  wire logic        I_FRAME_DONE,
  input  wire logic        I_TX_UNDERRUN,
  input  wire logic        I_FIFO_EMPTY,
  output logic             O_FIFO_FLUSH,
  output logic             O_UNDERRUN_ABORT,
  output logic             O_BYTE_COUNTER_EN,
  output logic             O_FRAMER_HOLD,
  // Transceiver pins
  output logic             O_SHUTDOWN_PIN,
  output logic             O_IR_TX_PIN,
  output logic             O_IR_TX_OVERRIDE,
  // Interrupt
  output logic             O_IRQ
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_s1_r;
  logic rst_n;

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [7:0]                ctrl_r;
  logic [7:0]                cfg_r;
  logic [`IRTXC_EV_W-1:0]    irq_sts_r;
  logic [`IRTXC_EV_W-1:0]    irq_msk_r;
  logic [`IRTXC_EV_W-1:0]    ev;
  logic [7:0]                awaddr_r;
  logic                      aw_have_r;
  logic [31:0]               wdata_r;
  logic [3:0]                wstrb_r;
  logic                      w_have_r;
  logic                      wr_fire;
  logic [31:0]               rdata_nxt;
  logic                      rd_ok;
  logic                      wr_ok;
  irtxc_pkg::irtxc_mode_t    mode;
  logic                      fast_mode;
  irtxc_pkg::irtxc_mp_state_t mp_r;
  irtxc_pkg::irtxc_pl_state_t pl_r;
  logic                      mp_start;
  logic                      pl_start;
  logic                      tm_start;
  logic [`IRTXC_CNT_W-1:0]   tm_len;
  logic                      tm_busy;
  logic                      tm_done;
  logic                      sd_level_r;
  logic                      tx_level_r;
  logic                      ctrl_wr;
  logic                      mp_fin;
  logic                      pl_fin;
  logic                      flush_fin;
  logic                      abort_ev;

  assign mode      = irtxc_pkg::irtxc_mode_t'(cfg_r[`IRTXC_B_MODE_LO+:2]);
  assign fast_mode = (mode == irtxc_pkg::IRTXC_MIR) || (mode == irtxc_pkg::IRTXC_FIR);

  // ----------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------
  assign O_AWREADY = !aw_have_r;
  assign O_WREADY  = !w_have_r;
  assign wr_fire   = aw_have_r && w_have_r && !O_BVALID;

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_r <= 1'b0;
      awaddr_r  <= 8'h00;
    end else if (I_AWVALID && O_AWREADY) begin
      aw_have_r <= 1'b1;
      awaddr_r  <= I_AWADDR;
    end else if (wr_fire) begin
      aw_have_r <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      w_have_r <= 1'b0;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end else if (I_WVALID && O_WREADY) begin
      w_have_r <= 1'b1;
      wdata_r  <= I_WDATA;
      wstrb_r  <= I_WSTRB;
    end else if (wr_fire) begin
      w_have_r <= 1'b0;
    end
  end

  always_comb begin
    if (awaddr_r == `IRTXC_OFS_CTRL1) begin
      wr_ok = 1'b1;
    end else if (awaddr_r == `IRTXC_OFS_CFG) begin
      wr_ok = 1'b1;
    end else if (awaddr_r == `IRTXC_OFS_IRQ_STS) begin
      wr_ok = 1'b1;
    end else if (awaddr_r == `IRTXC_OFS_IRQ_MSK) begin
      wr_ok = 1'b1;
    end else if (awaddr_r == `IRTXC_OFS_STATUS) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_BVALID <= 1'b0;
      O_BRESP  <= 2'h0;
    end else if (wr_fire) begin
      O_BVALID <= 1'b1;
      O_BRESP  <= wr_ok ? 2'h0 : 2'h2;
    end else if (I_BREADY) begin
      O_BVALID <= 1'b0;
    end
  end

  assign ctrl_wr = wr_fire && wstrb_r[0] && (awaddr_r == `IRTXC_OFS_CTRL1);

  // ----------------------------------------
  // Control register one
  // ----------------------------------------
  assign pl_fin    = (pl_r == irtxc_pkg::IRTXC_PL_DONE) && I_FRAME_DONE;
  assign mp_fin    = (mp_r == irtxc_pkg::IRTXC_MP_STEP2) && tm_done;
  assign flush_fin = ctrl_r[`IRTXC_B_FLUSH] && I_FIFO_EMPTY;

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `IRTXC_CTRL1_RST;
    end else begin
      if (ctrl_wr) begin
        ctrl_r <= wdata_r[7:0];
        if (!wdata_r[`IRTXC_B_PULSE] || !fast_mode) begin
          ctrl_r[`IRTXC_B_PULSE] <= 1'b0;
        end
      end else begin
        if (pl_fin) begin
          ctrl_r[`IRTXC_B_PULSE] <= 1'b0;
        end
        if (flush_fin) begin
          ctrl_r[`IRTXC_B_FLUSH] <= 1'b0;
        end
        if (mp_fin) begin
          ctrl_r[`IRTXC_B_MODEPROG] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Configuration register
  // ----------------------------------------
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= `IRTXC_CFG_RST;
    end else if (wr_fire && wstrb_r[0] && (awaddr_r == `IRTXC_OFS_CFG)) begin
      cfg_r <= wdata_r[7:0];
    end
  end

  // ----------------------------------------
  // Framer controls
  // ----------------------------------------
  assign O_FIFO_FLUSH      = ctrl_r[`IRTXC_B_FLUSH];
  assign O_UNDERRUN_ABORT  = ctrl_r[`IRTXC_B_BADCRC] && fast_mode;
  assign O_BYTE_COUNTER_EN = ctrl_r[`IRTXC_B_CNTEN] && (mode != irtxc_pkg::IRTXC_SIR);
  assign abort_ev          = O_UNDERRUN_ABORT && I_TX_UNDERRUN;
  assign O_FRAMER_HOLD     = (pl_r == irtxc_pkg::IRTXC_PL_EMIT);

  // ----------------------------------------
  // Shared interval timer
  // ----------------------------------------
  assign mp_start = (mp_r == irtxc_pkg::IRTXC_MP_IDLE) && ctrl_r[`IRTXC_B_MODEPROG]
                    && !tm_busy && (pl_r != irtxc_pkg::IRTXC_PL_EMIT);
  assign pl_start = (pl_r == irtxc_pkg::IRTXC_PL_WAIT) && I_CLOSING_FLAG
                    && (mp_r == irtxc_pkg::IRTXC_MP_IDLE) && !mp_start;

  always_comb begin
    tm_start = 1'b0;
    tm_len   = 8'(`IRTXC_STEP_CYC);
    if (pl_start) begin
      tm_start = 1'b1;
      tm_len   = 8'(`IRTXC_PULSE_CYC);
    end else if (mp_start) begin
      tm_start = 1'b1;
    end else if ((mp_r == irtxc_pkg::IRTXC_MP_STEP1) && tm_done) begin
      tm_start = 1'b1;
    end
  end

  irtxc_timer u_timer (
    .i_clk   (I_CLK),
    .i_rst_n (rst_n),
    .i_start (tm_start),
    .i_len   (tm_len),
    .o_busy  (tm_busy),
    .o_done  (tm_done)
  );

  // ----------------------------------------
  // Mode program sequencer
  // ----------------------------------------
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      mp_r <= irtxc_pkg::IRTXC_MP_IDLE;
    end else begin
      case (mp_r)
        irtxc_pkg::IRTXC_MP_IDLE: begin
          if (mp_start) begin
            mp_r <= irtxc_pkg::IRTXC_MP_STEP1;
          end
        end
        irtxc_pkg::IRTXC_MP_STEP1: begin
          if (tm_done) begin
            mp_r <= irtxc_pkg::IRTXC_MP_STEP2;
          end
        end
        irtxc_pkg::IRTXC_MP_STEP2: begin
          if (tm_done) begin
            mp_r <= irtxc_pkg::IRTXC_MP_IDLE;
          end
        end
        default: begin
          mp_r <= irtxc_pkg::IRTXC_MP_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Interaction pulse sequencer
  // ----------------------------------------
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pl_r <= irtxc_pkg::IRTXC_PL_IDLE;
    end else begin
      case (pl_r)
        irtxc_pkg::IRTXC_PL_IDLE: begin
          if (ctrl_r[`IRTXC_B_PULSE]) begin
            pl_r <= irtxc_pkg::IRTXC_PL_WAIT;
          end
        end
        irtxc_pkg::IRTXC_PL_WAIT: begin
          if (!ctrl_r[`IRTXC_B_PULSE]) begin
            pl_r <= irtxc_pkg::IRTXC_PL_IDLE;
          end else if (pl_start) begin
            pl_r <= irtxc_pkg::IRTXC_PL_EMIT;
          end
        end
        irtxc_pkg::IRTXC_PL_EMIT: begin
          if (tm_done) begin
            pl_r <= irtxc_pkg::IRTXC_PL_DONE;
          end
        end
        irtxc_pkg::IRTXC_PL_DONE: begin
          if (I_FRAME_DONE || !ctrl_r[`IRTXC_B_PULSE]) begin
            pl_r <= irtxc_pkg::IRTXC_PL_IDLE;
          end
        end
        default: begin
          pl_r <= irtxc_pkg::IRTXC_PL_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Transceiver pin drive
  // ----------------------------------------
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sd_level_r <= 1'b0;
    end else begin
      sd_level_r <= mp_start || ((mp_r == irtxc_pkg::IRTXC_MP_STEP1) && !tm_done);
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tx_level_r <= 1'b0;
    end else if (pl_start) begin
      tx_level_r <= 1'b1;
    end else if (mp_start) begin
      tx_level_r <= (mode == irtxc_pkg::IRTXC_FIR);
    end else if (mp_fin || ((pl_r == irtxc_pkg::IRTXC_PL_EMIT) && tm_done)) begin
      tx_level_r <= 1'b0;
    end
  end

  assign O_SHUTDOWN_PIN   = sd_level_r ^ cfg_r[`IRTXC_B_SD_INV];
  assign O_IR_TX_PIN      = tx_level_r;
  assign O_IR_TX_OVERRIDE = (mp_r != irtxc_pkg::IRTXC_MP_IDLE) ||
                            (pl_r == irtxc_pkg::IRTXC_PL_EMIT);

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  always_comb begin
    ev                     = '0;
    ev[`IRTXC_EV_PULSE]    = (pl_r == irtxc_pkg::IRTXC_PL_EMIT) && tm_done;
    ev[`IRTXC_EV_FLUSH]    = flush_fin;
    ev[`IRTXC_EV_ABORT]    = abort_ev;
    ev[`IRTXC_EV_MODEPROG] = mp_fin;
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_sts_r <= 4'h0;
    end else if (wr_fire && wstrb_r[0] && (awaddr_r == `IRTXC_OFS_IRQ_STS)) begin
      irq_sts_r <= (irq_sts_r & ~wdata_r[`IRTXC_EV_W-1:0]) | ev;
    end else begin
      irq_sts_r <= irq_sts_r | ev;
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_msk_r <= 4'h0;
    end else if (wr_fire && wstrb_r[0] && (awaddr_r == `IRTXC_OFS_IRQ_MSK)) begin
      irq_msk_r <= wdata_r[`IRTXC_EV_W-1:0];
    end
  end

  assign O_IRQ = |(irq_sts_r & irq_msk_r);

  // ----------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------
  assign O_ARREADY = !O_RVALID;

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    rd_ok     = 1'b1;
    if (I_ARADDR == `IRTXC_OFS_CTRL1) begin
      rdata_nxt[7:0] = ctrl_r;
    end else if (I_ARADDR == `IRTXC_OFS_CFG) begin
      rdata_nxt[7:0] = cfg_r;
    end else if (I_ARADDR == `IRTXC_OFS_STATUS) begin
      rdata_nxt[5:0] = {O_IR_TX_PIN, O_SHUTDOWN_PIN, pl_r, mp_r};
    end else if (I_ARADDR == `IRTXC_OFS_IRQ_STS) begin
      rdata_nxt[`IRTXC_EV_W-1:0] = irq_sts_r;
    end else if (I_ARADDR == `IRTXC_OFS_IRQ_MSK) begin
      rdata_nxt[`IRTXC_EV_W-1:0] = irq_msk_r;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_RVALID <= 1'b0;
      O_RDATA  <= 32'h0000_0000;
      O_RRESP  <= 2'h0;
    end else if (I_ARVALID && O_ARREADY) begin
      O_RVALID <= 1'b1;
      O_RDATA  <= rdata_nxt;
      O_RRESP  <= rd_ok ? 2'h0 : 2'h2;
    end else if (I_RREADY) begin
      O_RVALID <= 1'b0;
    end
  end

endmodule

// File: irtxc_xcvr_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Transceiver pin watcher
// ----------------------------------------
module irtxc_xcvr_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Pins
  input  wire logic       i_shutdown_pin,
  input  wire logic       i_ir_tx_pin,
  input  wire logic       i_active_low,
  // Observed
  output logic            o_fir_seen,
  output logic [7:0]      o_shut_cyc,
  output logic [7:0]      o_pulse_cyc
);
  logic       shut_act;
  logic [7:0] shut_cnt_r;
  logic [7:0] tx_cnt_r;
  assign shut_act = i_shutdown_pin ^ i_active_low;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shut_cnt_r <= 8'h00;
      o_shut_cyc <= 8'h00;
      o_fir_seen <= 1'b0;
    end else if (shut_act) begin
      shut_cnt_r <= shut_cnt_r + 8'h01;
    end else begin
      if (shut_cnt_r != 8'h00) begin
        o_shut_cyc <= shut_cnt_r;
        o_fir_seen <= i_ir_tx_pin;
      end
      shut_cnt_r <= 8'h00;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_cnt_r    <= 8'h00;
      o_pulse_cyc <= 8'h00;
    end else if (i_ir_tx_pin && !shut_act) begin
      tx_cnt_r <= tx_cnt_r + 8'h01;
    end else begin
      if (tx_cnt_r != 8'h00) begin
        o_pulse_cyc <= tx_cnt_r;
      end
      tx_cnt_r <= 8'h00;
    end
  end
endmodule

// File: irtxc_top_props.sv
`timescale 1ns/1ps
module irtxc_top_props (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic I_CLOSING_FLAG,
  input wire logic I_FIFO_EMPTY,
  input wire logic I_BREADY,
  input wire logic O_BVALID,
  input wire logic O_RVALID,
  input wire logic O_ARREADY,
  input wire logic O_FIFO_FLUSH,
  input wire logic O_FRAMER_HOLD,
  input wire logic O_SHUTDOWN_PIN,
  input wire logic O_IR_TX_PIN,
  input wire logic O_IR_TX_OVERRIDE
);
  logic [7:0] hold_cnt_r;
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      hold_cnt_r <= 8'h00;
    end else begin
      hold_cnt_r <= O_FRAMER_HOLD ? hold_cnt_r + 8'h01 : 8'h00;
    end
  end
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);
  property p_flush_end;
    O_FIFO_FLUSH && I_FIFO_EMPTY |=> !O_FIFO_FLUSH;
  endproperty
  a_flush_end: assert property (p_flush_end) else $error("flush stays after empty");
  property p_pulse_len;
    $fell(O_FRAMER_HOLD) |-> hold_cnt_r == 8'h28;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse length wrong");
  property p_pulse_start;
    $rose(O_FRAMER_HOLD) |-> $past(I_CLOSING_FLAG) || $past(I_CLOSING_FLAG, 2);
  endproperty
  a_pulse_start: assert property (p_pulse_start) else $error("pulse without flag");
  property p_pulse_tx;
    O_FRAMER_HOLD |-> O_IR_TX_PIN && O_IR_TX_OVERRIDE && $stable(O_SHUTDOWN_PIN);
  endproperty
  a_pulse_tx: assert property (p_pulse_tx) else $error("pulse pin levels wrong");
  property p_shut_len;
    $rose(O_IR_TX_OVERRIDE) && !O_FRAMER_HOLD |-> $changed(O_SHUTDOWN_PIN)
      ##1 $stable(O_SHUTDOWN_PIN) [*5] ##1 $changed(O_SHUTDOWN_PIN);
  endproperty
  a_shut_len: assert property (p_shut_len) else $error("shutdown step wrong");
  property p_tx_hold;
    $rose(O_IR_TX_OVERRIDE) && !O_FRAMER_HOLD |=> $stable(O_IR_TX_PIN) [*8];
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx level moved early");
  property p_tx_end;
    $fell(O_IR_TX_OVERRIDE) && !$past(O_FRAMER_HOLD) |-> !O_IR_TX_PIN;
  endproperty
  a_tx_end: assert property (p_tx_end) else $error("tx not low at end");
  property p_b_stand;
    O_BVALID && !I_BREADY |=> O_BVALID;
  endproperty
  a_b_stand: assert property (p_b_stand) else $error("write response dropped");
  property p_ar_gate;
    O_RVALID |-> !O_ARREADY;
  endproperty
  a_ar_gate: assert property (p_ar_gate) else $error("read address open");
endmodule
bind irtxc_top irtxc_top_props u_props (.I_CLK, .I_ARST_N, .I_CLOSING_FLAG, .I_FIFO_EMPTY,
  .I_BREADY, .O_BVALID, .O_RVALID, .O_ARREADY, .O_FIFO_FLUSH, .O_FRAMER_HOLD, .O_SHUTDOWN_PIN,
  .O_IR_TX_PIN, .O_IR_TX_OVERRIDE);

// File: irda_tx_control_bits_test.sv
`timescale 1ns/1ps
`include "irtxc_regs.svh"
module irda_tx_control_bits_test;
  typedef struct {logic [1:0] mode; logic inv; logic fir;} irtxc_row_t;
  irtxc_row_t  rows [8];
  logic        clk, arst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        cflag, fdone, unrun, fempty, inv, fir_seen, irq_a;
  logic [7:0]  awaddr, araddr, shut_cyc, pulse_cyc;
  logic [31:0] wdata, rdat;
  logic [1:0]  resp;
  logic        o_awr, o_wr, o_bv, o_arr, o_rv, o_flush, o_abort, o_cen, o_hold, o_shut;
  logic        o_tx, o_ovr, o_irq;
  logic [1:0]  o_bresp, o_rresp;
  logic [31:0] o_rdata;
  int          failures, n_checks, cyc, k;
  irtxc_top DUT (.I_CLK(clk), .I_ARST_N(arst_n), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(o_awr), .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid), .O_WREADY(o_wr),
    .O_BRESP(o_bresp), .O_BVALID(o_bv), .I_BREADY(bready), .I_ARADDR(araddr),
    .I_ARVALID(arvalid), .O_ARREADY(o_arr), .O_RDATA(o_rdata), .O_RRESP(o_rresp),
    .O_RVALID(o_rv), .I_RREADY(rready), .I_CLOSING_FLAG(cflag), .I_FRAME_DONE(fdone),
    .I_TX_UNDERRUN(unrun), .I_FIFO_EMPTY(fempty), .O_FIFO_FLUSH(o_flush),
    .O_UNDERRUN_ABORT(o_abort), .O_BYTE_COUNTER_EN(o_cen), .O_FRAMER_HOLD(o_hold),
    .O_SHUTDOWN_PIN(o_shut), .O_IR_TX_PIN(o_tx), .O_IR_TX_OVERRIDE(o_ovr), .O_IRQ(o_irq));
  irtxc_xcvr_model u_xcvr (.i_clk(clk), .i_rst_n(arst_n), .i_shutdown_pin(o_shut),
    .i_ir_tx_pin(o_tx), .i_active_low(inv), .o_fir_seen(fir_seen), .o_shut_cyc(shut_cyc),
    .o_pulse_cyc(pulse_cyc));
  // ----------------------------------------
  // Clock, timeout, checks
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      $display("wrong value at %0t: timeout", $time);
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  // ----------------------------------------
  // AXI4-Lite master
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge clk);
      aw = awvalid && o_awr;
      w = wvalid && o_wr;
      b = o_bv;
      resp = o_bresp;
      @(posedge clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a);
    logic ar, r;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r = 1'b0;
    while (!r) begin
      @(negedge clk);
      ar = arvalid && o_arr;
      r = o_rv;
      rdat = o_rdata;
      resp = o_rresp;
      @(posedge clk);
      if (ar) arvalid <= 1'b0;
      if (r) rready <= 1'b0;
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {arst_n, awvalid, wvalid, bready, arvalid, rready, cflag, fdone, unrun, fempty} = '0;
    {awaddr, araddr, wdata, inv} = '0;
    for (k = 0; k < 8; k++) rows[k] = '{mode: k[1:0], inv: k[2], fir: (k[1:0] == 2'h3)};
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk_bit(o_shut, 1'b0, "reset shutdown");
    chk_bit(o_awr & o_wr & o_arr & ~o_irq, 1'b1, "reset readies");
    rd(`IRTXC_OFS_CTRL1);
    chk_word(rdat, 32'h0, "reset ctrl");
    rd(`IRTXC_OFS_CFG);
    chk_word(rdat, 32'h0, "reset cfg");
    rd(8'h14);
    chk_word({rdat[29:0], resp}, 32'h2, "unmapped read");
    wr(8'h14, 32'hFF);
    chk_word({30'h0, resp}, 32'h2, "unmapped write");
    $display("test reset done");
    for (k = 0; k < 8; k++) begin
      wr(`IRTXC_OFS_CFG, {29'h0, rows[k].inv, rows[k].mode});
      inv <= rows[k].inv;
      wr(`IRTXC_OFS_CTRL1, 32'h80);
      rdat = 32'h80;
      for (int t = 0; t < 20 && rdat[7]; t++) rd(`IRTXC_OFS_CTRL1);
      chk_word(rdat, 32'h0, "mode prog bit");
      chk_bit(fir_seen, rows[k].fir, "tx level at release");
      chk_word({24'h0, shut_cyc}, 32'h6, "shutdown cycles");
      chk_bit(o_shut, rows[k].inv, "shutdown idle level");
    end
    $display("test mode program done");
    wr(`IRTXC_OFS_CFG, 32'h0);
    inv <= 1'b0;
    wr(`IRTXC_OFS_CTRL1, 32'h08);
    rd(`IRTXC_OFS_CTRL1);
    chk_word(rdat, 32'h0, "pulse req in sir");
    wr(`IRTXC_OFS_CFG, 32'h2);
    wr(`IRTXC_OFS_CTRL1, 32'h08);
    cflag <= 1'b1;
    @(posedge clk);
    cflag <= 1'b0;
    repeat (50) @(posedge clk);
    chk_word({24'h0, pulse_cyc}, 32'h28, "pulse cycles");
    rd(`IRTXC_OFS_CTRL1);
    chk_word(rdat, 32'h08, "pulse bit before frame end");
    fdone <= 1'b1;
    @(posedge clk);
    fdone <= 1'b0;
    rd(`IRTXC_OFS_CTRL1);
    chk_word(rdat, 32'h0, "pulse bit after frame end");
    rd(`IRTXC_OFS_IRQ_STS);
    chk_bit(rdat[`IRTXC_EV_PULSE], 1'b1, "pulse event");
    $display("test pulse done");
    wr(`IRTXC_OFS_CTRL1, 32'h10);
    @(negedge clk);
    chk_bit(o_flush, 1'b1, "flush out");
    rd(`IRTXC_OFS_CTRL1);
    chk_word(rdat, 32'h10, "flush bit held");
    fempty <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk_bit(o_flush, 1'b0, "flush ends");
    rd(`IRTXC_OFS_IRQ_STS);
    chk_bit(rdat[`IRTXC_EV_FLUSH], 1'b1, "flush event");
    wr(`IRTXC_OFS_IRQ_MSK, 32'h0);
    @(negedge clk);
    irq_a = o_irq;
    wr(`IRTXC_OFS_IRQ_MSK, 32'hF);
    @(negedge clk);
    chk_bit(irq_a ^ o_irq, 1'b1, "mask changes irq");
    wr(`IRTXC_OFS_IRQ_STS, 32'hF);
    rd(`IRTXC_OFS_IRQ_STS);
    chk_word(rdat, 32'h0, "irq cleared");
    chk_bit(o_irq, 1'b0, "irq low");
    $display("test flush and irq done");
    for (k = 0; k < 4; k++) begin
      wr(`IRTXC_OFS_CFG, k);
      wr(`IRTXC_OFS_CTRL1, 32'h60);
      @(negedge clk);
      chk_bit(o_abort, k >= 2, "abort enable");
      chk_bit(o_cen, k != 0, "counter enable");
      @(posedge clk);
      unrun <= 1'b1;
      @(posedge clk);
      unrun <= 1'b0;
      rd(`IRTXC_OFS_IRQ_STS);
      chk_bit(rdat[`IRTXC_EV_ABORT], k >= 2, "abort event");
      wr(`IRTXC_OFS_IRQ_STS, 32'hF);
      wr(`IRTXC_OFS_CTRL1, 32'h0);
      @(negedge clk);
      chk_bit(o_abort | o_cen, 1'b0, "enables cleared");
    end
    $display("test enables done");
    give_verdict();
  end
endmodule
